// ===== logic/ssr_defines.svh
// Offsets, field positions, reset values and constants of the slave serial receiver.
// Behaviour
// - single-receive enable has no effect in slave mode
// - continuous receive keeps working while the core sleeps
// - finished word moves from shifter into data buffer
// - received word with enable raises wake-up interrupt
// - global enable also branches to fixed vector
// - data pin input, clock pin cleared before use
// - slave mode is sync, port enable, no clock source
// - nine-bit enable gives 9-bit words, ninth in status
// - reception starts only after continuous receive enable
// - flag set per word; interrupt only when enabled
// - status shows ninth bit and errors, read first
// - low eight bits read from data buffer
// - clearing continuous receive clears pending errors
// - unimplemented bits read back as zero
// - buffer read loads ninth bit of next word
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH
// Register offsets.
`define SSR_OFS_IRQ_FLAGS 8'h0C
`define SSR_OFS_RX_STATUS 8'h18
`define SSR_OFS_RX_DATA 8'h1A
`define SSR_OFS_IRQ_ENABLES 8'h8C
`define SSR_OFS_TX_STATUS 8'h98
`define SSR_OFS_BAUD 8'h99
`define SSR_OFS_EVT_STATUS 8'h20
`define SSR_OFS_EVT_MASK 8'h21
`define SSR_OFS_PORT_DIR 8'h22
`define SSR_OFS_CORE_CTRL 8'h23
// Receive status and control field positions.
`define SSR_RS_PORT_EN 7
`define SSR_RS_NINE 6
`define SSR_RS_SINGLE 5
`define SSR_RS_CONT 4
`define SSR_RS_FRAME 2
`define SSR_RS_OVERRUN 1
`define SSR_RS_NINTH 0
// Transmit status and control field positions and writable bits.
`define SSR_TS_CLK_SRC 7
`define SSR_TS_SYNC 4
`define SSR_TS_WR_MASK 8'hF5
// Flag and enable position of the receive event.
`define SSR_PIR_RX 5
// Port direction bits of the data and clock pins.
`define SSR_DIR_DATA 1
`define SSR_DIR_CLK 2
// Own event status bits.
`define SSR_EVT_WORD 0
`define SSR_EVT_OVERRUN 1
// Reset values.
`define SSR_RST_ZERO 8'h00
`define SSR_RST_TX_STATUS 8'h02
`define SSR_RST_PORT_DIR 8'hFF
// Interrupt vector address.
`define SSR_IRQ_VECTOR 13'h0004
// Index of the last bit of a word.
`define SSR_LAST_EIGHT 4'h7
`define SSR_LAST_NINE 4'h8
`endif

// ===== logic/ssr_pkg.sv
// Types shared by the slave serial receiver modules.
package ssr_pkg;
	// Shifter states, one-hot.
	typedef enum logic [1:0] {
		SSR_IDLE = 2'b01,
		SSR_SHIFT = 2'b10
	} ssr_shift_state_t;
endpackage

// ===== logic/ssr_link_if.sv
// Link between the register side and the bit shifter.
interface ssr_link_if;
	logic run;        // Reception allowed.
	logic nine_bit;   // Nine-bit words selected.
	logic clk_s;      // Synchronised shift clock.
	logic data_s;     // Synchronised data pin.
	logic done;       // One-cycle pulse: word complete.
	logic [8:0] word; // Finished word, ninth bit on top.
	modport shifter(input run, nine_bit, clk_s, data_s, output done, word);
	modport ctrl(output run, nine_bit, clk_s, data_s, input done, word);
endinterface

// ===== logic/ssr_sync.sv
// Two-flop synchroniser for pin levels.
module ssr_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Levels in and out.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// First stage; read only by the second stage.
	logic [WIDTH-1:0] meta_reg;
	// Both stages clear on reset and shift every edge.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// ===== logic/ssr_shifter.sv
// Bit shifter: assembles words from the external shift clock.
`include "ssr_defines.svh"
module ssr_shifter (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Link to the register side.
	ssr_link_if.shifter lnk
);
	ssr_pkg::ssr_shift_state_t state_reg, state_next; // Shifter state.
	logic clk_prev_reg;     // Shift clock one cycle ago.
	logic [3:0] cnt_reg;    // Bits taken in this word.
	logic [8:0] shreg_reg;  // Receive shift register.
	logic done_reg;         // Completion pulse.
	logic [8:0] word_reg;   // Last finished word.
	wire in_shift = (state_reg == ssr_pkg::SSR_SHIFT) & lnk.run;
	// Data is taken on the falling edge of the shift clock.
	wire fall = clk_prev_reg & ~lnk.clk_s;
	wire [8:0] shifted = {lnk.data_s, shreg_reg[8:1]};
	wire [3:0] last = lnk.nine_bit ? `SSR_LAST_NINE : `SSR_LAST_EIGHT;
	wire last_bit = in_shift & fall & (cnt_reg == last);
	assign lnk.done = done_reg;
	assign lnk.word = word_reg;
	// Leave idle only when reception is allowed; drop back when it stops.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ssr_pkg::SSR_IDLE: if (lnk.run) state_next = ssr_pkg::SSR_SHIFT;
			ssr_pkg::SSR_SHIFT: if (!lnk.run) state_next = ssr_pkg::SSR_IDLE;
			default: state_next = ssr_pkg::SSR_IDLE;
		endcase
	end
	// Shift bits in LSB first and hand over each finished word.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= ssr_pkg::SSR_IDLE;
			clk_prev_reg <= 1'b0;
			cnt_reg <= 4'h0;
			shreg_reg <= 9'h000;
			done_reg <= 1'b0;
			word_reg <= 9'h000;
		end else begin
			state_reg <= state_next;
			clk_prev_reg <= lnk.clk_s;
			done_reg <= last_bit;
			if (!in_shift) begin
				cnt_reg <= 4'h0;
			end else if (fall) begin
				cnt_reg <= last_bit ? 4'h0 : cnt_reg + 4'h1;
				shreg_reg <= shifted;
			end
			// An 8-bit word sits one place high in the shifter.
			if (last_bit) begin
				word_reg <= lnk.nine_bit ? shifted : {1'b0, shifted[8:1]};
			end
		end
	end
endmodule

// ===== logic/ssr_top.sv
// Receive path of a serial port in synchronous slave mode, with registers and interrupts.
//
// The plain strobed port is this design's own decision.
`include "ssr_defines.svh"
module ssr_top (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Serial clock pin, driven by the master.
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	// Serial data pin, driven by the master.
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe,
	// Interrupt, wake-up and vector request.
	output logic irq,
	output logic wake_req,
	output logic vector_req,
	output logic [12:0] vector_addr
);
	// Address match, shared by the write and read decoders.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	ssr_link_if lnk(); // Link to the bit shifter.
	logic [1:0] pins_sync; // Synchronised clock and data pins.

	// Software state.
	logic [7:3] rs_ctrl_reg;  // Port enable, nine-bit, single, continuous, address detect.
	logic [7:0] ts_ctrl_reg;  // Transmit control, writable bits; reset also loads bit 1.
	logic [7:0] baud_reg;     // Baud divisor, unused in slave mode.
	logic [7:0] pie_reg;      // Peripheral interrupt enables.
	logic [7:0] port_dir_reg; // Port B direction.
	logic gie_reg;            // Global interrupt enable.
	logic [1:0] evt_status_reg; // Sticky event bits.
	logic [1:0] evt_mask_reg;   // Event mask.
	// Receive buffer, two words deep, ninth bit on top.
	logic [8:0] buf0_reg;
	logic [8:0] buf1_reg;
	logic [1:0] count_reg;
	logic overrun_error_flag_reg; // Overrun error.

	// Pin sampling through two flops.
	ssr_sync #(.WIDTH(2)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.async_in({serial_clock_pin_in, serial_data_pin_in}),
		.sync_out(pins_sync)
	);

	// Bit shifter.
	ssr_shifter u_shifter (
		.mclk(mclk),
		.rst(rst),
		.lnk(lnk.shifter)
	);

	// Field views.
	wire port_en = rs_ctrl_reg[`SSR_RS_PORT_EN];
	wire nine_en = rs_ctrl_reg[`SSR_RS_NINE];
	wire single_en = rs_ctrl_reg[`SSR_RS_SINGLE];
	wire cont_en = rs_ctrl_reg[`SSR_RS_CONT];
	wire clk_src = ts_ctrl_reg[`SSR_TS_CLK_SRC];
	wire sync_en = ts_ctrl_reg[`SSR_TS_SYNC];
	wire rx_ie = pie_reg[`SSR_PIR_RX];

	// Slave mode: synchronous, port on, clock from outside.
	wire slave_mode = sync_en & port_en & ~clk_src;
	// Pins serve the port only with data as input and clock bit cleared.
	wire pins_ok = port_dir_reg[`SSR_DIR_DATA] & ~port_dir_reg[`SSR_DIR_CLK];
	// The single-receive bit is left out on purpose; only continuous receive starts the shifter.
	// Nothing here looks at a sleep state, so reception goes on while the core sleeps.
	wire rx_run = slave_mode & pins_ok & cont_en & ~overrun_error_flag_reg;

	assign lnk.run = rx_run;
	assign lnk.nine_bit = nine_en;
	assign lnk.clk_s = pins_sync[1];
	assign lnk.data_s = pins_sync[0];

	// Write decode.
	wire wr_rs = reg_wr & hit(reg_addr, `SSR_OFS_RX_STATUS);
	wire wr_ts = reg_wr & hit(reg_addr, `SSR_OFS_TX_STATUS);
	wire wr_baud = reg_wr & hit(reg_addr, `SSR_OFS_BAUD);
	wire wr_pie = reg_wr & hit(reg_addr, `SSR_OFS_IRQ_ENABLES);
	wire wr_dir = reg_wr & hit(reg_addr, `SSR_OFS_PORT_DIR);
	wire wr_core = reg_wr & hit(reg_addr, `SSR_OFS_CORE_CTRL);
	wire wr_evt = reg_wr & hit(reg_addr, `SSR_OFS_EVT_STATUS);
	wire wr_mask = reg_wr & hit(reg_addr, `SSR_OFS_EVT_MASK);

	// Buffer movement: a read pops, a finished word pushes.
	wire rd_data = reg_rd & hit(reg_addr, `SSR_OFS_RX_DATA);
	wire buf_empty = (count_reg == 2'h0);
	wire buf_full = (count_reg == 2'h2);
	wire pop = rd_data & ~buf_empty;
	wire push = lnk.done & ~buf_full;
	wire overrun = lnk.done & buf_full;
	wire [1:0] count_next = count_reg + {1'b0, push} - {1'b0, pop};
	// The head takes the second word on a pop, or the new word when it would be empty.
	wire [8:0] buf0_next = (pop & buf_full) ? buf1_reg :
		((push & (buf_empty | (pop & count_reg == 2'h1))) ? lnk.word : buf0_reg);
	wire [8:0] buf1_next = (push & ~pop & count_reg == 2'h1) ? lnk.word : buf1_reg;
	// The flag follows the buffer: set by a word, cleared by reading it empty.
	wire rx_flag = ~buf_empty;

	// Overrun: set wins; cleared only by dropping continuous receive.
	wire overrun_error_flag_next = overrun | (overrun_error_flag_reg & cont_en);

	// Sticky events, cleared by writing ones; a new event wins.
	wire [1:0] evt_set = {overrun, lnk.done};
	wire [1:0] evt_clr = wr_evt ? reg_wdata[1:0] : 2'h0;
	wire [1:0] evt_next = evt_set | (evt_status_reg & ~evt_clr);

	// Interrupt, wake-up and vector.
	wire wake_next = rx_flag & rx_ie;
	wire vector_next = wake_next & gie_reg;

	// Register views on read; unimplemented bits are zero.
	wire [7:0] rs_view = {rs_ctrl_reg, 1'b0, overrun_error_flag_reg, buf0_reg[8]};
	wire [7:0] pir_view = {2'h0, rx_flag, 5'h00};
	wire [7:0] ts_view = (ts_ctrl_reg & `SSR_TS_WR_MASK) | `SSR_RST_TX_STATUS;
	wire [7:0] rd_mux =
		hit(reg_addr, `SSR_OFS_IRQ_FLAGS) ? pir_view :
		hit(reg_addr, `SSR_OFS_RX_STATUS) ? rs_view :
		hit(reg_addr, `SSR_OFS_RX_DATA) ? buf0_reg[7:0] :
		hit(reg_addr, `SSR_OFS_IRQ_ENABLES) ? pie_reg :
		hit(reg_addr, `SSR_OFS_TX_STATUS) ? ts_view :
		hit(reg_addr, `SSR_OFS_BAUD) ? baud_reg :
		hit(reg_addr, `SSR_OFS_EVT_STATUS) ? {6'h00, evt_status_reg} :
		hit(reg_addr, `SSR_OFS_EVT_MASK) ? {6'h00, evt_mask_reg} :
		hit(reg_addr, `SSR_OFS_PORT_DIR) ? port_dir_reg :
		hit(reg_addr, `SSR_OFS_CORE_CTRL) ? {7'h00, gie_reg} : `SSR_RST_ZERO;

	// Control registers written by software.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rs_ctrl_reg <= 5'h00;
			ts_ctrl_reg <= `SSR_RST_TX_STATUS;
			baud_reg <= `SSR_RST_ZERO;
			pie_reg <= `SSR_RST_ZERO;
			port_dir_reg <= `SSR_RST_PORT_DIR;
			gie_reg <= 1'b0;
			evt_mask_reg <= 2'h0;
		end else begin
			if (wr_rs) rs_ctrl_reg <= reg_wdata[7:3];
			if (wr_ts) ts_ctrl_reg <= reg_wdata & `SSR_TS_WR_MASK;
			if (wr_baud) baud_reg <= reg_wdata;
			if (wr_pie) pie_reg <= reg_wdata;
			if (wr_dir) port_dir_reg <= reg_wdata;
			if (wr_core) gie_reg <= reg_wdata[0];
			if (wr_mask) evt_mask_reg <= reg_wdata[1:0];
		end
	end

	// Receive buffer, error and event state.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			buf0_reg <= 9'h000;
			buf1_reg <= 9'h000;
			count_reg <= 2'h0;
			overrun_error_flag_reg <= 1'b0;
			evt_status_reg <= 2'h0;
		end else begin
			buf0_reg <= buf0_next;
			buf1_reg <= buf1_next;
			count_reg <= count_next;
			overrun_error_flag_reg <= overrun_error_flag_next;
			evt_status_reg <= evt_next;
		end
	end

	// Output flops; the pins are never driven.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata <= `SSR_RST_ZERO;
			irq <= 1'b0;
			wake_req <= 1'b0;
			vector_req <= 1'b0;
			vector_addr <= 13'h0000;
			serial_clock_pin_out <= 1'b0;
			serial_clock_pin_oe <= 1'b0;
			serial_data_pin_out <= 1'b0;
			serial_data_pin_oe <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : `SSR_RST_ZERO;
			irq <= |(evt_status_reg & evt_mask_reg);
			wake_req <= wake_next;
			vector_req <= vector_next;
			vector_addr <= vector_next ? `SSR_IRQ_VECTOR : 13'h0000;
			serial_clock_pin_out <= 1'b0;
			serial_clock_pin_oe <= 1'b0;
			serial_data_pin_out <= 1'b0;
			serial_data_pin_oe <= 1'b0;
		end
	end

	// Checks on the receive path.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Single receive alone never starts the shifter.
	a_single_ignored: assert property (single_en && !cont_en |-> !lnk.run)
		else $error("single receive started reception");
	// No word completes unless reception ran the cycle before.
	a_start_gate: assert property (!lnk.run |=> !lnk.done)
		else $error("word completed without continuous receive");
	// A word into an empty buffer lands in the head.
	a_word_buffer: assert property (lnk.done && buf_empty |=> count_reg == 2'h1 && buf0_reg == $past(lnk.word))
		else $error("finished word not moved to buffer");
	// A held word with the enable set raises wake-up next cycle.
	a_wake_raise: assert property (rx_flag && rx_ie |=> wake_req)
		else $error("wake request missing");
	// With the global enable the vector is requested.
	a_vector_req: assert property (rx_flag && rx_ie && gie_reg |=> vector_req && vector_addr == 13'h0004)
		else $error("vector request missing");
	// Wrong pin directions hold reception off.
	a_pin_dir: assert property (!pins_ok |-> !lnk.run)
		else $error("reception with wrong pin directions");
	// Internal clock source excludes slave reception.
	a_mode_sel: assert property (clk_src || !sync_en || !port_en |-> !lnk.run)
		else $error("reception outside slave mode");
	// Eight-bit words carry a zero ninth bit.
	a_eight_word: assert property (lnk.done && !nine_en && $past(!nine_en) |-> lnk.word[8] == 1'b0)
		else $error("ninth bit set in 8-bit word");
	// A stored word raises the flag.
	a_flag_set: assert property (push |=> rx_flag)
		else $error("receive flag not set");
	// A pop from a full buffer brings up the next ninth bit.
	a_ninth_next: assert property (pop && buf_full |=> rs_view[0] == $past(buf1_reg[8]))
		else $error("ninth bit not reloaded");
	// Data read returns the head's low byte.
	a_data_read: assert property (rd_data |=> reg_rdata == $past(buf0_reg[7:0]))
		else $error("wrong receive data");
	// Two cycles without continuous receive leave no error.
	a_err_clear: assert property (!cont_en ##1 !cont_en |=> !overrun_error_flag_reg)
		else $error("error not cleared");
	// Unused flag bits read zero.
	a_flag_zero: assert property (reg_rd && hit(reg_addr, `SSR_OFS_IRQ_FLAGS) |=> (reg_rdata & 8'hDF) == 8'h00)
		else $error("unimplemented bits not zero");
	// The clock pin is never driven.
	a_clk_free: assert property (!serial_clock_pin_oe)
		else $error("clock pin driven");

	c_word_in: cover property (push ##[1:200] pop);
	c_overrun: cover property (overrun);
	c_nine_word: cover property (lnk.done && nine_en);
	c_wake: cover property (vector_req);
endmodule

// ===== verif/ssr_master_model.sv
// Behavioural model of the external synchronous master that drives shift clock and data.
module ssr_master_model (
	// Shift clock and data towards the receiver.
	output logic sclk,
	output logic sdata
);
	timeunit 1ns;
	timeprecision 10ps;

	// The clock idles high and stands still between frames.
	initial begin
		sclk = 1'b1;
		sdata = 1'b0;
	end

	// Shifts out n bits, lowest first, with a 125 ns period; data is set up half a phase before each fall.
	task automatic send(input logic [8:0] w, input int n);
		for (int i = 0; i < n; i++) begin
			sdata = w[i];
			#31.25;
			sclk = 1'b0;
			#62.5;
			sclk = 1'b1;
			#31.25;
		end
		// Released line has no pull, so it shows the inverse of the last bit.
		sdata = ~sdata;
	endtask
endmodule

// ===== verif/sync_slave_serial_receiver_tb_top.sv
// Self-checking testbench of the slave serial receiver, driven over its register port.
`define CHK(nm, exp, got) begin \
	n_checks++; \
	if ((got) !== (exp)) begin \
		fails++; \
		$display("BAD %s expected %h seen %h", nm, exp, got); \
	end \
end
module sync_slave_serial_receiver_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	// Core clock and reset.
	logic mclk;
	logic rst;
	// Register port.
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	// Pin outputs of the receiver and wires of the master model.
	logic clk_out, clk_oe, dat_out, dat_oe, m_clk, m_dat, clk_pin, dat_pin;
	// Interrupt side.
	logic irq, wake_req, vector_req;
	logic [12:0] vector_addr;
	// Counters of mismatches and comparisons.
	int fails = 0;
	int n_checks = 0;
	// Reset values: address and expected read.
	logic [7:0] ra[11] = '{8'h0C, 8'h18, 8'h1A, 8'h8C, 8'h98, 8'h99, 8'h20, 8'h21, 8'h22, 8'h23, 8'h55};
	logic [7:0] rv[11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
	// Wrong set-ups: one register spoiled at a time.
	logic [7:0] bad_a[3] = '{8'h98, 8'h22, 8'h98};
	logic [7:0] bad_v[3] = '{8'h90, 8'h06, 8'h00};

	// Each pin level comes from whichever party enables its driver.
	assign clk_pin = clk_oe ? clk_out : m_clk;
	assign dat_pin = dat_oe ? dat_out : m_dat;

	ssr_top dut (
		.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_clock_pin_in(clk_pin),
		.serial_clock_pin_out(clk_out), .serial_clock_pin_oe(clk_oe), .serial_data_pin_in(dat_pin),
		.serial_data_pin_out(dat_out), .serial_data_pin_oe(dat_oe), .irq(irq), .wake_req(wake_req),
		.vector_req(vector_req), .vector_addr(vector_addr)
	);

	ssr_master_model mdl (
		.sclk(m_clk),
		.sdata(m_dat)
	);

	// Core clock, 8 ns period.
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Waits n edges, then lets their updates land.
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// One-cycle write strobe.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// One-cycle read strobe; data is taken in the following cycle.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Reads a register and compares it.
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHK(nm, e, d)
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		// Reset values, an unmapped place among them.
		for (int i = 0; i < 11; i++) begin
			rd_chk("reset value", ra[i], rv[i]);
		end
		// Unimplemented bits read zero; read-only and unmapped writes change nothing.
		wr(8'h98, 8'hFF);
		rd_chk("tx control", 8'h98, 8'hF7);
		wr(8'h99, 8'h5A);
		rd_chk("baud", 8'h99, 8'h5A);
		wr(8'h1A, 8'h33);
		wr(8'h55, 8'h77);
		rd_chk("data ro", 8'h1A, 8'h00);
		rd_chk("unmapped", 8'h55, 8'h00);
		// Slave set-up with only single receive set: nothing must arrive.
		wr(8'h98, 8'h10);
		wr(8'h22, 8'h02);
		wr(8'h18, 8'hA0);
		mdl.send(9'h0A5, 8);
		tick(2);
		rd_chk("flags idle", 8'h0C, 8'h00);
		// Each wrong set-up blocks reception.
		for (int i = 0; i < 3; i++) begin
			wr(8'h18, 8'h90);
			wr(bad_a[i], bad_v[i]);
			mdl.send(9'h0A5, 8);
			tick(2);
			rd_chk("flags bad cfg", 8'h0C, 8'h00);
			wr(8'h98, 8'h10);
			wr(8'h22, 8'h02);
		end
		// Continuous receive with single receive also set; event masked in, receive enable off.
		wr(8'h18, 8'hB0);
		wr(8'h21, 8'h01);
		mdl.send(9'h0A5, 8);
		tick(2);
		rd_chk("flag set", 8'h0C, 8'h20);
		`CHK("wake off", 1'b0, wake_req)
		`CHK("irq on", 1'b1, irq)
		wr(8'h8C, 8'h20);
		tick(2);
		`CHK("wake on", 1'b1, wake_req)
		`CHK("vector off", 1'b0, vector_req)
		wr(8'h23, 8'h01);
		tick(2);
		`CHK("vector on", 1'b1, vector_req)
		`CHK("vector addr", 13'h0004, vector_addr)
		rd_chk("event", 8'h20, 8'h01);
		rd_chk("status 8", 8'h18, 8'hB0);
		rd_chk("data 8", 8'h1A, 8'hA5);
		tick(2);
		`CHK("wake cleared", 1'b0, wake_req)
		rd_chk("flag clear", 8'h0C, 8'h00);
		wr(8'h20, 8'h01);
		tick(2);
		`CHK("irq cleared", 1'b0, irq)
		// Two nine-bit words back to back; status is read before data.
		wr(8'h18, 8'hD0);
		mdl.send(9'h1A5, 9);
		mdl.send(9'h03C, 9);
		tick(2);
		rd_chk("status ninth 1", 8'h18, 8'hD1);
		rd_chk("data nine a", 8'h1A, 8'hA5);
		rd_chk("status ninth 0", 8'h18, 8'hD0);
		rd_chk("data nine b", 8'h1A, 8'h3C);
		// Third word into a full buffer sets overrun; clearing continuous receive clears it.
		wr(8'h18, 8'h90);
		mdl.send(9'h011, 8);
		mdl.send(9'h022, 8);
		mdl.send(9'h033, 8);
		tick(2);
		rd_chk("overrun", 8'h18, 8'h92);
		rd_chk("event overrun", 8'h20, 8'h03);
		wr(8'h18, 8'h80);
		rd_chk("overrun cleared", 8'h18, 8'h80);
		rd_chk("kept 1", 8'h1A, 8'h11);
		rd_chk("kept 2", 8'h1A, 8'h22);
		wr(8'h18, 8'h90);
		mdl.send(9'h044, 8);
		tick(2);
		rd_chk("resumed", 8'h1A, 8'h44);
		// The receiver never drives either pin.
		`CHK("clock oe", 1'b0, clk_oe)
		`CHK("data oe", 1'b0, dat_oe)
		`CHK("clock out", 1'b0, clk_out)
		`CHK("data out", 1'b0, dat_out)
		stop_test();
	end
endmodule
